/* shared/pm_cfg_pkg.sv */
/*
 * Constants and carrier types for the power management and configuration
 * access block. Assumes a synchronous ISA-style strobe interface sampled
 * on the block clock.
 */
package pm_cfg_pkg;

    // ========================================
    // Configuration access ports
    // ========================================
    localparam logic [9:0] BASE_STRAP_LOW  = 10'h3F0;
    localparam logic [9:0] BASE_STRAP_HIGH = 10'h370;
    localparam logic [9:0] DATA_PORT_STEP  = 10'h001;
    localparam logic [7:0] ENTRY_KEY       = 8'h55;
    localparam logic [7:0] EXIT_KEY        = 8'hAA;
    localparam logic [5:0] LAST_INDEX      = 6'h2F;
    localparam int         NUM_REGS        = 48;

    // ========================================
    // Configuration register indexes and fields
    // ========================================
    localparam logic [5:0] IDX_CR01     = 6'h01;
    localparam logic [5:0] IDX_CR02     = 6'h02;
    localparam logic [5:0] IDX_CR04     = 6'h04;
    localparam logic [5:0] IDX_CR07     = 6'h07;
    localparam int         CR01_PP_PWR  = 2;
    localparam int         CR01_PP_MODE = 3;
    localparam int         CR02_U1_PWR  = 3;
    localparam int         CR02_U2_PWR  = 7;
    localparam int         CR04_EXT_LO  = 0;
    localparam int         CR07_PP_APM  = 4;
    localparam int         CR07_U2_APM  = 5;
    localparam int         CR07_U1_APM  = 6;
    localparam int         CR07_FD_APM  = 7;

    // Parallel extended mode field of CR04
    localparam logic [1:0] PPX_SPP      = 2'h0;
    localparam logic [1:0] PPX_EPP      = 2'h1;
    localparam logic [1:0] PPX_ECP      = 2'h2;
    localparam logic [1:0] PPX_ECP_EPP  = 2'h3;

    // Mode field of the extended control register
    localparam logic [2:0] ECR_SPP      = 3'h0;
    localparam logic [2:0] ECR_BIDIR    = 3'h1;
    localparam logic [2:0] ECR_EPP      = 3'h4;

    // ========================================
    // Reset values of the first registers
    // ========================================
    localparam logic [7:0] RESET_CR00 = 8'h28;
    localparam logic [7:0] RESET_CR01 = 8'h9C;
    localparam logic [7:0] RESET_CR02 = 8'h88;
    localparam logic [7:0] RESET_CR03 = 8'h70;
    localparam logic [7:0] RESET_CR06 = 8'hFF;
    localparam logic [7:0] RESET_CR0C = 8'h02;
    localparam logic [7:0] RESET_CR0D = 8'h28;
    localparam logic [7:0] RESET_CR11 = 8'h80;
    localparam logic [7:0] RESET_CR17 = 8'h03;
    localparam logic [7:0] RESET_CR1E = 8'h80;
    localparam logic [7:0] RESET_CR20 = 8'h3C;

    // ========================================
    // Carriers
    // ========================================
    typedef struct packed {
        logic [3:0] motor_on;
        logic [3:0] drive_sel;
        logic       write_bit;
        logic       write_gate;
        logic       direction;
        logic       step;
        logic       side;
        logic       density;
        logic [1:0] rate;
    } fdd_pins_t;

    typedef struct packed {
        logic tx_empty;
        logic tsr_empty;
        logic rx_fifo_empty;
        logic rx_idle;
        logic tx_write;
        logic rx_data;
        logic ring;
    } uart_stat_t;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b01,
        ST_CONFIG = 2'b10
    } cfg_state_t;

endpackage

/* rtl/uart_pd_ctrl.sv */
/*
 * Auto powerdown control of one serial port: transmitter and receiver
 * powerdown, wake events and ring indicate interrupt.
 * Assumes status inputs are synchronous to clk_i.
 */
`timescale 1ns/100ps
module uart_pd_ctrl (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   direct_pd_i,
    input  wire logic                   auto_en_i,
    input  wire pm_cfg_pkg::uart_stat_t stat_i,
    output logic                        tx_pd_o,
    output logic                        rx_pd_o,
    output logic                        ring_irq_o
);

    logic tx_pd_q, tx_pd_d, rx_pd_q, rx_pd_d;
    logic rx_last_q, ring_last_q, ring_irq_q;

    wire tx_wake   = stat_i.tx_write;
    wire rx_wake   = stat_i.rx_data ^ rx_last_q;
    wire tx_idle   = stat_i.tx_empty & stat_i.tsr_empty;
    wire rx_quiet  = stat_i.rx_fifo_empty & stat_i.rx_idle;

    // Wake has priority over re-entry in the same cycle
    assign tx_pd_d = auto_en_i & ~tx_wake & tx_idle;
    assign rx_pd_d = auto_en_i & ~rx_wake & rx_quiet;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_pd_q     <= 1'b0;
            rx_pd_q     <= 1'b0;
            rx_last_q   <= 1'b1;
            ring_last_q <= 1'b0;
            ring_irq_q  <= 1'b0;
        end else begin
            tx_pd_q     <= tx_pd_d;
            rx_pd_q     <= rx_pd_d;
            rx_last_q   <= stat_i.rx_data;
            ring_last_q <= stat_i.ring;
            ring_irq_q  <= stat_i.ring ^ ring_last_q;
        end
    end

    assign tx_pd_o    = direct_pd_i | tx_pd_q;
    assign rx_pd_o    = direct_pd_i | rx_pd_q;
    assign ring_irq_o = ring_irq_q;

    AST_TX_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        stat_i.tx_write |=> !tx_pd_q) else $error("tx not woken by write");
    AST_TX_ENTER: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_en_i && tx_idle && !tx_wake |=> tx_pd_q)
        else $error("tx did not power down");
    AST_RX_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
        !(stat_i.rx_fifo_empty && stat_i.rx_idle) |=> !rx_pd_q)
        else $error("rx down while busy");
    AST_RING: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(stat_i.ring) |=> ring_irq_o)
        else $error("ring change missed");

endmodule

/* rtl/power_mgmt_config_access.sv */
/*
 * Power management and configuration access: floppy pin gating in auto
 * powerdown, serial and parallel powerdown control, and the keyed
 * configuration state behind index and data ports.
 * Assumes ISA strobes and address are synchronous to clk_i, one-cycle
 * strobes per access, and a power-on reset separate from hardware reset.
 */
`timescale 1ns/100ps
module power_mgmt_config_access (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   hw_reset_i,
    input  wire logic                   base_select_strap_i,
    input  wire logic [9:0]             addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   io_write_i,
    input  wire logic                   io_read_i,
    output logic [7:0]                  rdata_o,
    output logic                        rdata_oe_o,
    input  wire logic                   floppy_auto_pd_i,
    input  wire logic                   floppy_irq_i,
    input  wire pm_cfg_pkg::fdd_pins_t  fdd_core_i,
    output pm_cfg_pkg::fdd_pins_t       fdd_pins_o,
    output pm_cfg_pkg::fdd_pins_t       fdd_oe_o,
    output logic                        floppy_irq_out_o,
    output logic                        floppy_auto_en_o,
    input  wire pm_cfg_pkg::uart_stat_t uart1_stat_i,
    input  wire pm_cfg_pkg::uart_stat_t uart2_stat_i,
    output logic                        uart1_tx_pd_o,
    output logic                        uart1_rx_pd_o,
    output logic                        uart1_ring_irq_o,
    output logic                        uart2_tx_pd_o,
    output logic                        uart2_rx_pd_o,
    output logic                        uart2_ring_irq_o,
    input  wire logic [2:0]             ecr_mode_i,
    output logic                        pp_pd_o,
    output logic                        epp_pd_o,
    output logic                        ecp_pd_o,
    output logic                        config_active_o
);

    // ========================================
    // Reset value table
    // ========================================
    function automatic logic [7:0] reset_value(input logic [5:0] idx);
        case (idx)
            6'h00:   reset_value = pm_cfg_pkg::RESET_CR00;
            6'h01:   reset_value = pm_cfg_pkg::RESET_CR01;
            6'h02:   reset_value = pm_cfg_pkg::RESET_CR02;
            6'h03:   reset_value = pm_cfg_pkg::RESET_CR03;
            6'h06:   reset_value = pm_cfg_pkg::RESET_CR06;
            6'h0C:   reset_value = pm_cfg_pkg::RESET_CR0C;
            6'h0D:   reset_value = pm_cfg_pkg::RESET_CR0D;
            6'h11:   reset_value = pm_cfg_pkg::RESET_CR11;
            6'h17:   reset_value = pm_cfg_pkg::RESET_CR17;
            6'h1E:   reset_value = pm_cfg_pkg::RESET_CR1E;
            6'h20:   reset_value = pm_cfg_pkg::RESET_CR20;
            default: reset_value = 8'h00;
        endcase
    endfunction

    // ========================================
    // Strap capture on hardware reset release
    // ========================================
    logic hw_reset_q, strap_q;
    wire  hw_reset_fall = hw_reset_q & ~hw_reset_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hw_reset_q <= 1'b0;
            strap_q    <= 1'b0;
        end else begin
            hw_reset_q <= hw_reset_i;
            if (hw_reset_fall) begin
                strap_q <= base_select_strap_i;
            end
        end
    end

    // ========================================
    // Port decode
    // ========================================
    wire [9:0] base_addr  = strap_q ? pm_cfg_pkg::BASE_STRAP_HIGH
                                    : pm_cfg_pkg::BASE_STRAP_LOW;
    wire [9:0] data_addr  = base_addr + pm_cfg_pkg::DATA_PORT_STEP;
    wire       hit_base   = (addr_i == base_addr);
    wire       hit_data   = (addr_i == data_addr);

    pm_cfg_pkg::cfg_state_t state_q, state_d;
    wire in_cfg = (state_q == pm_cfg_pkg::ST_CONFIG);

    wire key_wr      = io_write_i & hit_base & ~in_cfg;
    wire index_wr    = io_write_i & hit_base & in_cfg;
    wire index_rd    = io_read_i & hit_base & in_cfg;
    wire data_wr     = io_write_i & hit_data & in_cfg;
    wire data_rd     = io_read_i & hit_data & in_cfg;
    wire exit_wr     = index_wr & (wdata_i == pm_cfg_pkg::EXIT_KEY);

    // ========================================
    // Configuration state machine
    // ========================================
    always_comb begin
        state_d = state_q;
        case (state_q)
            pm_cfg_pkg::ST_RUN: begin
                // Any other value is dropped
                if (key_wr && wdata_i == pm_cfg_pkg::ENTRY_KEY) begin
                    state_d = pm_cfg_pkg::ST_CONFIG;
                end
            end
            pm_cfg_pkg::ST_CONFIG: begin
                if (exit_wr) begin
                    state_d = pm_cfg_pkg::ST_RUN;
                end
            end
            default: state_d = pm_cfg_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= pm_cfg_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================
    // Select register and register array
    // ========================================
    logic [7:0] select_q;
    logic [7:0] regs_q [pm_cfg_pkg::NUM_REGS];
    wire        idx_valid = (select_q <= {2'b00, pm_cfg_pkg::LAST_INDEX});
    wire [5:0]  idx       = select_q[5:0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            select_q <= 8'h00;
        end else if (index_wr && !exit_wr) begin
            select_q <= wdata_i;
        end
    end

    // Power-on only: hardware reset leaves contents alone
    genvar gi;
    generate
        for (gi = 0; gi < pm_cfg_pkg::NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    regs_q[gi] <= reset_value(6'(gi));
                end else if (data_wr && idx_valid && idx == 6'(gi)) begin
                    regs_q[gi] <= wdata_i;
                end
            end
        end
    endgenerate

    // ========================================
    // Host read data
    // ========================================
    wire [7:0] rd_sel = index_rd ? select_q
                      : (idx_valid ? regs_q[idx] : 8'h00);
    logic [7:0] rdata_q;
    logic       rdata_oe_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q    <= 8'h00;
            rdata_oe_q <= 1'b0;
        end else begin
            rdata_q    <= rd_sel;
            rdata_oe_q <= index_rd | data_rd;
        end
    end

    assign rdata_o         = rdata_q;
    assign rdata_oe_o      = rdata_oe_q;
    assign config_active_o = in_cfg;

    // ========================================
    // Floppy pins in auto powerdown
    // ========================================
    wire [7:0] cr01 = regs_q[pm_cfg_pkg::IDX_CR01];
    wire [7:0] cr02 = regs_q[pm_cfg_pkg::IDX_CR02];
    wire [7:0] cr04 = regs_q[pm_cfg_pkg::IDX_CR04];
    wire [7:0] cr07 = regs_q[pm_cfg_pkg::IDX_CR07];

    assign floppy_auto_en_o = cr07[pm_cfg_pkg::CR07_FD_APM];
    // Host side keeps working; irq output forced to its low level
    assign floppy_irq_out_o = floppy_irq_i & ~floppy_auto_pd_i;
    assign fdd_pins_o       = fdd_core_i;

    always_comb begin
        fdd_oe_o            = '1;
        fdd_oe_o.motor_on   = {4{~floppy_auto_pd_i}};
        fdd_oe_o.drive_sel  = {4{~floppy_auto_pd_i}};
        fdd_oe_o.write_bit  = ~floppy_auto_pd_i;
        fdd_oe_o.write_gate = ~floppy_auto_pd_i;
        fdd_oe_o.direction  = 1'b1;
        fdd_oe_o.step       = 1'b1;
        fdd_oe_o.side       = 1'b1;
        fdd_oe_o.density    = 1'b1;
        fdd_oe_o.rate       = 2'b11;
    end

    // ========================================
    // Serial ports
    // ========================================
    uart_pd_ctrl u_uart1 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .direct_pd_i (~cr02[pm_cfg_pkg::CR02_U1_PWR]),
        .auto_en_i   (cr07[pm_cfg_pkg::CR07_U1_APM]),
        .stat_i      (uart1_stat_i),
        .tx_pd_o     (uart1_tx_pd_o),
        .rx_pd_o     (uart1_rx_pd_o),
        .ring_irq_o  (uart1_ring_irq_o)
    );

    uart_pd_ctrl u_uart2 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .direct_pd_i (~cr02[pm_cfg_pkg::CR02_U2_PWR]),
        .auto_en_i   (cr07[pm_cfg_pkg::CR07_U2_APM]),
        .stat_i      (uart2_stat_i),
        .tx_pd_o     (uart2_tx_pd_o),
        .rx_pd_o     (uart2_rx_pd_o),
        .ring_irq_o  (uart2_ring_irq_o)
    );

    // ========================================
    // Parallel port, re-evaluated every cycle from live mode fields
    // ========================================
    wire [1:0] ppx      = cr04[pm_cfg_pkg::CR04_EXT_LO +: 2];
    wire       pp_apm   = cr07[pm_cfg_pkg::CR07_PP_APM];
    wire       epp_cfg  = (ppx == pm_cfg_pkg::PPX_EPP) || (ppx == pm_cfg_pkg::PPX_ECP_EPP);
    wire       ecp_cfg  = (ppx == pm_cfg_pkg::PPX_ECP) || (ppx == pm_cfg_pkg::PPX_ECP_EPP);
    wire       ecr_std  = (ecr_mode_i == pm_cfg_pkg::ECR_SPP)
                        || (ecr_mode_i == pm_cfg_pkg::ECR_BIDIR);
    wire       ecr_epp  = (ecr_mode_i == pm_cfg_pkg::ECR_EPP);

    assign pp_pd_o  = ~cr01[pm_cfg_pkg::CR01_PP_PWR];
    assign epp_pd_o = pp_pd_o | (pp_apm & (~epp_cfg | (ecp_cfg & ~ecr_epp)));
    assign ecp_pd_o = pp_pd_o | (pp_apm & (~ecp_cfg | ecr_std | ecr_epp));

    // ========================================
    // Checks
    // ========================================
    sequence key_written;
        io_write_i && hit_base && !in_cfg && wdata_i == pm_cfg_pkg::ENTRY_KEY;
    endsequence

    sequence exit_written;
        io_write_i && hit_base && in_cfg && wdata_i == pm_cfg_pkg::EXIT_KEY;
    endsequence

    AST_ENTER_KEY: assert property (@(posedge clk_i) disable iff (rst_i)
        key_written |=> in_cfg) else $error("key did not enter config");
    AST_EXIT_KEY: assert property (@(posedge clk_i) disable iff (rst_i)
        exit_written |=> !in_cfg) else $error("exit key ignored");
    AST_BAD_KEY: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_cfg && !(key_wr && wdata_i == pm_cfg_pkg::ENTRY_KEY) |=> !in_cfg)
        else $error("left run without key");
    AST_STAY_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
        in_cfg && !exit_wr |=> in_cfg) else $error("config dropped");
    AST_NO_READ_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_cfg |=> !rdata_oe_o) else $error("port answered in run");
    AST_DATA_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        data_wr && idx_valid |=> regs_q[$past(idx)] == $past(wdata_i))
        else $error("data write lost");
    AST_FDD_TRI: assert property (@(posedge clk_i) disable iff (rst_i)
        floppy_auto_pd_i |-> fdd_oe_o.motor_on == 4'h0 && !fdd_oe_o.write_gate
        && fdd_oe_o.step && !floppy_irq_out_o) else $error("floppy pins wrong");
    AST_ECP_PD: assert property (@(posedge clk_i) disable iff (rst_i)
        pp_apm && ecr_epp |-> ecp_pd_o) else $error("ecp logic left up");
    AST_STRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_reset_fall |=> strap_q == $past(base_select_strap_i))
        else $error("strap not latched");

endmodule

/* tb/isa_host_model.sv */
/*
 * Host bus model: one-cycle ISA-style read and write strobes.
 * Assumes the bench clock; drives at the falling edge.
 */
`timescale 1ns/100ps
module isa_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_oe_i,
    output logic [9:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            io_write_o,
    output logic            io_read_o
);
    initial begin
        addr_o = 10'h000;
        wdata_o = 8'h00;
        io_write_o = 1'b0;
        io_read_o = 1'b0;
    end

    // Keys, index and data all go out as single writes
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        io_write_o = 1'b1;
        @(negedge clk_i);
        io_write_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // Answer stands from the taking edge, read half a cycle later
    task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
        @(negedge clk_i);
        addr_o = a;
        io_read_o = 1'b1;
        @(negedge clk_i);
        io_read_o = 1'b0;
        d = rdata_i;
        oe = rdata_oe_i;
        addr_o = ~a;
    endtask
endmodule

/* tb/tb_top.sv */
/*
 * Bench top: hand-written access tests, table rows for parallel powerdown, then more hand-written tests.
 * Assumes the host model makes every register access.
 */
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [7:0] cr04;
        logic [2:0] ecr;
        logic       enhanced_parallel_mode;
        logic       extended_capabilities_mode;
    } pp_row_t;
    localparam pp_row_t ROWS [7] = '{
        '{8'h00, 3'h0, 1'b1, 1'b1}, '{8'h01, 3'h0, 1'b0, 1'b1},
        '{8'h02, 3'h0, 1'b1, 1'b1}, '{8'h02, 3'h3, 1'b1, 1'b0},
        '{8'h03, 3'h4, 1'b0, 1'b1}, '{8'h03, 3'h3, 1'b1, 1'b0},
        '{8'h03, 3'h1, 1'b1, 1'b1}};

    logic                   clk_i = 1'b0;
    logic                   rst_i, hw_rst, strap, fd_apd, fd_irq, fd_irq_o, fd_auto_en;
    logic [2:0]             ecr;
    logic [9:0]             addr, base;
    logic [7:0]             wdata, rdata, rd_d;
    logic                   io_wr, io_rd, rdata_oe, rd_oe, cfg_act, pp_pd, epp_pd, ecp_pd;
    logic                   u1_tx, u1_rx, u1_ring, u2_tx, u2_rx, u2_ring;
    pm_cfg_pkg::fdd_pins_t  fd_core, fd_pins, fd_oe;
    pm_cfg_pkg::uart_stat_t u1, u2;
    int                     fail_count = 0;
    int                     checks_done = 0;

    always #50 clk_i = ~clk_i;

    isa_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .rdata_oe_i(rdata_oe),
        .addr_o(addr), .wdata_o(wdata), .io_write_o(io_wr), .io_read_o(io_rd));

    power_mgmt_config_access dut_u (.clk_i(clk_i), .rst_i(rst_i), .hw_reset_i(hw_rst),
        .base_select_strap_i(strap), .addr_i(addr), .wdata_i(wdata), .io_write_i(io_wr),
        .io_read_i(io_rd), .rdata_o(rdata), .rdata_oe_o(rdata_oe),
        .floppy_auto_pd_i(fd_apd), .floppy_irq_i(fd_irq), .fdd_core_i(fd_core),
        .fdd_pins_o(fd_pins), .fdd_oe_o(fd_oe), .floppy_irq_out_o(fd_irq_o),
        .floppy_auto_en_o(fd_auto_en), .uart1_stat_i(u1), .uart2_stat_i(u2),
        .uart1_tx_pd_o(u1_tx), .uart1_rx_pd_o(u1_rx), .uart1_ring_irq_o(u1_ring),
        .uart2_tx_pd_o(u2_tx), .uart2_rx_pd_o(u2_rx), .uart2_ring_irq_o(u2_ring),
        .ecr_mode_i(ecr), .pp_pd_o(pp_pd), .epp_pd_o(epp_pd), .ecp_pd_o(ecp_pd),
        .config_active_o(cfg_act));

    // ========================================
    // Checking and access helpers
    // ========================================
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cfg_wr(input logic [5:0] idx, input logic [7:0] val);
        host_u.wr(base, {2'h0, idx});
        host_u.wr(base + pm_cfg_pkg::DATA_PORT_STEP, val);
    endtask

    task automatic cfg_rd(input logic [5:0] idx, input logic [7:0] exp);
        host_u.wr(base, {2'h0, idx});
        host_u.rd(base + pm_cfg_pkg::DATA_PORT_STEP, rd_d, rd_oe);
        chk({rd_oe, rd_d}, {1'b1, exp}, "data read");
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(100 * 3000);
        fail_count++;
        test_done();
    end

    // ========================================
    // Tests
    // ========================================
    initial begin
        rst_i = 1'b1;
        {hw_rst, strap, fd_apd, fd_irq} = 4'h0;
        fd_core = '0;
        u1 = '0;
        u2 = '0;
        u1.rx_data = 1'b1;
        u2.rx_data = 1'b1;
        ecr = 3'h0;
        base = pm_cfg_pkg::BASE_STRAP_LOW;
        tick(3);
        rst_i = 1'b0;
        chk({cfg_act, pp_pd, u1_tx, u1_rx}, 4'h0, "reset");
        host_u.rd(base, rd_d, rd_oe);
        chk(rd_oe, 1'b0, "index hidden");
        host_u.wr(base, pm_cfg_pkg::EXIT_KEY);
        host_u.wr(base, 8'h12);
        chk(cfg_act, 1'b0, "stray key");
        host_u.wr(base, pm_cfg_pkg::ENTRY_KEY);
        chk(cfg_act, 1'b1, "enter");
        cfg_wr(pm_cfg_pkg::IDX_CR07, 8'hF0);
        cfg_rd(pm_cfg_pkg::IDX_CR07, 8'hF0);
        host_u.rd(base, rd_d, rd_oe);
        chk({rd_oe, rd_d, fd_auto_en}, {1'b1, 8'h07, 1'b1}, "index back");
        $display("test access done");
        foreach (ROWS[i]) begin
            cfg_wr(pm_cfg_pkg::IDX_CR04, ROWS[i].cr04);
            ecr = ROWS[i].ecr;
            tick(1);
            chk({epp_pd, ecp_pd}, {ROWS[i].enhanced_parallel_mode, ROWS[i].extended_capabilities_mode}, "pp row");
        end
        $display("test parallel rows done");
        fd_core = '1;
        fd_irq = 1'b1;
        tick(1);
        chk({fd_oe, fd_irq_o}, 17'h1FFFF, "fdd awake");
        fd_apd = 1'b1;
        tick(1);
        chk(fd_oe, 16'h003F, "fdd gated");
        chk(fd_pins, 16'hFFFF, "fdd levels");
        chk({fd_irq_o, cfg_act}, 2'b01, "irq low");
        host_u.rd(base, rd_d, rd_oe);
        chk({rd_oe, rd_d}, {1'b1, 8'h04}, "host live");
        fd_apd = 1'b0;
        $display("test floppy done");
        u1.tx_empty = 1'b1;
        tick(2);
        chk(u1_tx, 1'b0, "tx busy");
        u1.tsr_empty = 1'b1;
        tick(1);
        chk(u1_tx, 1'b1, "tx sleep");
        u1.tx_write = 1'b1;
        tick(1);
        chk(u1_tx, 1'b0, "tx wake");
        u1.tx_write = 1'b0;
        u1.rx_fifo_empty = 1'b1;
        tick(2);
        chk(u1_rx, 1'b0, "rx busy");
        u1.rx_idle = 1'b1;
        tick(1);
        chk(u1_rx, 1'b1, "rx sleep");
        u1.ring = 1'b1;
        tick(1);
        chk(u1_ring, 1'b1, "ring irq");
        tick(1);
        chk(u1_ring, 1'b0, "ring pulse");
        u1.rx_data = 1'b0;
        tick(1);
        chk(u1_rx, 1'b0, "rx wake");
        cfg_wr(pm_cfg_pkg::IDX_CR02, 8'h08);
        chk({u2_tx, u2_rx}, 2'b11, "uart direct");
        cfg_wr(pm_cfg_pkg::IDX_CR02, pm_cfg_pkg::RESET_CR02);
        chk({u2_tx, u2_rx, u2_ring}, 3'b000, "uart up");
        cfg_wr(pm_cfg_pkg::IDX_CR01, 8'h98);
        chk(pp_pd, 1'b1, "pp direct");
        cfg_wr(pm_cfg_pkg::IDX_CR01, pm_cfg_pkg::RESET_CR01);
        chk(pp_pd, 1'b0, "pp up");
        host_u.wr(base, pm_cfg_pkg::EXIT_KEY);
        chk(cfg_act, 1'b0, "exit");
        host_u.rd(base + pm_cfg_pkg::DATA_PORT_STEP, rd_d, rd_oe);
        chk(rd_oe, 1'b0, "data hidden");
        $display("test serial and exit done");
        strap = 1'b1;
        hw_rst = 1'b1;
        tick(2);
        hw_rst = 1'b0;
        tick(2);
        strap = 1'b0;
        host_u.wr(base, pm_cfg_pkg::ENTRY_KEY);
        chk(cfg_act, 1'b0, "old base");
        base = pm_cfg_pkg::BASE_STRAP_HIGH;
        host_u.wr(base, pm_cfg_pkg::ENTRY_KEY);
        chk(cfg_act, 1'b1, "new base");
        cfg_rd(pm_cfg_pkg::IDX_CR07, 8'hF0);
        host_u.wr(base, pm_cfg_pkg::EXIT_KEY);
        $display("test strap done");
        test_done();
    end
endmodule
